// *** hdl/status_led_pkg.sv ***
// constants and types for the charger status indicator
package status_led_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned FAST_HZ = 5;
    localparam int unsigned SLOW_HZ = 1;
    // half period counts in clock cycles
    localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
    // flash code: on and off slots at fast half period, pause in slots
    localparam int unsigned FLASH_PAUSE_SLOTS = 6;

    // ----------------------------------------
    // operating states from the charging state machine
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_INACTIVE = 4'h0,
        OP_PREHEAT = 4'h1,
        OP_WAIT_ENABLE = 4'h2,
        OP_WAIT_CABLE = 4'h3,
        OP_WAIT_VEHICLE = 4'h4,
        OP_CHARGING = 4'h5,
        OP_EMERG_UNLOCK = 4'h6,
        OP_NET_CONFIG = 4'h7,
        OP_LINK_DOWN = 4'h8,
        OP_WAIT_CLIENT = 4'h9,
        OP_IN_OPERATION = 4'hA,
        OP_NO_FIRMWARE = 4'hB
    } op_state_t;

    // ----------------------------------------
    // fault bit positions, lowest bit has highest priority
    // ----------------------------------------
    localparam int unsigned FAULT_W = 7;
    localparam int unsigned FLT_PILOT_SHORT = 0;
    localparam int unsigned FLT_PILOT_INVALID = 1;
    localparam int unsigned FLT_RCCB = 2;
    localparam int unsigned FLT_LINE_PROT = 3;
    localparam int unsigned FLT_TEMP = 4;
    localparam int unsigned FLT_HUMIDITY = 5;
    localparam int unsigned FLT_CABLE = 6;

    typedef enum logic [1:0] {
        PAT_OFF,
        PAT_STEADY,
        PAT_FAST,
        PAT_SLOW
    } pattern_t;
endpackage

// *** hdl/charger_status_led_sequencer.sv ***
// status led sequencer for the charging controller
`timescale 1ns/1ps
// Functional notes
// [R1] network client waits for answer between requests
// [R2] one led, orange is red plus green
// [R3] dark while inactive or powering up
// [R4] standalone preheating: orange blink 5 Hz
// [R5] standalone waiting enable: orange blink 1 Hz
// [R6] standalone awaiting cable: green blink 5 Hz
// [R7] standalone awaiting vehicle: green blink 1 Hz
// [R8] steady green charging or managed operating
// [R9] standalone emergency unlocking: red blink 5 Hz
// [R10] identify mode: red/green alternate 1 Hz
// [R11] managed network configuration: red blink 5 Hz
// [R12] managed link down: red blink 1 Hz
// [R13] managed waiting client: green blink 1 Hz
// [R14] pilot short one flash, invalid two
// [R15] rccb three flashes, line switch four
// [R16] temperature five flashes, humidity six
// [R17] wrong cable seven red flashes
// [R18] managed no firmware: steady orange
// [R19] station signals current limit and readiness
// [R20] vehicle signals its charging state
// [R21] fault flash code overrides, repeats while present; the code flashes in standalone only
// [R22] all rates from one prescaler
module charger_status_led_sequencer #(
    parameter int unsigned FAST_HALF = status_led_pkg::FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF = status_led_pkg::SLOW_HALF_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_managed,
    input wire status_led_pkg::op_state_t i_op_state,
    input wire logic [status_led_pkg::FAULT_W-1:0] i_fault,
    input wire logic [status_led_pkg::FAULT_W-1:0] i_fault_monitor_en,
    input wire logic i_identify,
    output logic o_led_red,
    output logic o_led_green
);
    import status_led_pkg::*;

    localparam int FW = $clog2(FAST_HALF + 1);
    localparam int RATIO = (SLOW_HALF + FAST_HALF - 1) / FAST_HALF;
    localparam int RW = $clog2(RATIO + 1);
    localparam logic [FW-1:0] FAST_LAST = FW'(FAST_HALF - 1);
    localparam logic [RW-1:0] RATIO_LAST = RW'(RATIO - 1);
    localparam logic [4:0] PAUSE_SLOTS = 5'(FLASH_PAUSE_SLOTS);

    // ----------------------------------------
    // prescaler: fast tick every fast half period
    // ----------------------------------------
    logic [FW-1:0] pre_q, pre_d;
    logic [RW-1:0] div_q, div_d;
    logic fast_ph_q, fast_ph_d;
    logic slow_ph_q, slow_ph_d;
    logic tick;

    // slow phase flips every RATIO fast ticks, exact when SLOW_HALF is a multiple of FAST_HALF
    always_comb begin
        tick = (pre_q == FAST_LAST);
        pre_d = tick ? '0 : pre_q + FW'(1);
        div_d = div_q;
        fast_ph_d = fast_ph_q;
        slow_ph_d = slow_ph_q;
        if (tick) begin
            fast_ph_d = ~fast_ph_q;
            if (div_q == RATIO_LAST) begin
                div_d = '0;
                slow_ph_d = ~slow_ph_q;
            end else begin
                div_d = div_q + RW'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pre_q <= '0; // [R22]
            div_q <= '0;
            fast_ph_q <= 1'b0;
            slow_ph_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            div_q <= div_d;
            fast_ph_q <= fast_ph_d;
            slow_ph_q <= slow_ph_d;
        end
    end

    // ----------------------------------------
    // fault selection, lowest index first
    // ----------------------------------------
    logic [FAULT_W-1:0] fault_act;
    logic fault_any;
    logic [2:0] fault_cnt;

    always_comb begin
        // flash codes exist only in the standalone variant
        fault_act = i_managed ? '0 : (i_fault & i_fault_monitor_en); // [R15] [R16]
        fault_any = |fault_act;
        fault_cnt = 3'h0;
        for (int i = FAULT_W - 1; i >= 0; i--) begin
            if (fault_act[i]) begin
                fault_cnt = 3'(i + 1); // [R14] [R15] [R16] [R17]
            end
        end
    end

    // ----------------------------------------
    // flash burst sequencer, one slot per fast tick
    // ----------------------------------------
    typedef enum logic [1:0] {
        FS_IDLE,
        FS_ON,
        FS_OFF,
        FS_PAUSE
    } flash_st_t;

    // left_q: flashes still to show in this burst
    flash_st_t fst_q, fst_d;
    logic [2:0] left_q, left_d;
    logic [4:0] pcnt_q, pcnt_d;

    always_comb begin
        fst_d = fst_q;
        left_d = left_q;
        pcnt_d = pcnt_q;
        case (fst_q)
            FS_IDLE: begin
                if (fault_any && tick) begin
                    fst_d = FS_ON;
                    left_d = fault_cnt;
                end
            end
            FS_ON: begin
                if (tick) begin
                    fst_d = FS_OFF;
                    left_d = left_q - 3'h1;
                end
            end
            FS_OFF: begin
                if (tick) begin
                    if (left_q == 3'h0) begin
                        fst_d = FS_PAUSE;
                        pcnt_d = '0;
                    end else begin
                        fst_d = FS_ON;
                    end
                end
            end
            FS_PAUSE: begin
                if (tick) begin
                    if (pcnt_q == PAUSE_SLOTS - 5'h1) begin
                        // straight into the next burst: gap is one off slot plus the pause
                        fst_d = FS_ON; // [R21]
                        left_d = fault_cnt;
                    end else begin
                        pcnt_d = pcnt_q + 5'h1;
                    end
                end
            end
            default: fst_d = FS_IDLE;
        endcase
        if (!fault_any) begin
            fst_d = FS_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            fst_q <= FS_IDLE;
            left_q <= 3'h0;
            pcnt_q <= 5'h0;
        end else begin
            fst_q <= fst_d;
            left_q <= left_d;
            pcnt_q <= pcnt_d;
        end
    end

    // ----------------------------------------
    // pattern selection and led drive
    // ----------------------------------------
    logic red_d;
    logic green_d;
    logic red_q;
    logic green_q;
    logic cr;
    logic cg;
    pattern_t pat;

    always_comb begin
        cr = 1'b0;
        cg = 1'b0;
        pat = PAT_OFF;
        // codes foreign to the selected variant leave the led dark
        if (!i_managed) begin
            case (i_op_state)
                OP_PREHEAT: begin
                    cr = 1'b1; // [R4]
                    cg = 1'b1;
                    pat = PAT_FAST;
                end
                OP_WAIT_ENABLE: begin
                    cr = 1'b1; // [R5]
                    cg = 1'b1;
                    pat = PAT_SLOW;
                end
                OP_WAIT_CABLE: begin
                    cg = 1'b1; // [R6]
                    pat = PAT_FAST;
                end
                OP_WAIT_VEHICLE: begin
                    cg = 1'b1; // [R7]
                    pat = PAT_SLOW;
                end
                OP_CHARGING: begin
                    cg = 1'b1; // [R8]
                    pat = PAT_STEADY;
                end
                OP_EMERG_UNLOCK: begin
                    cr = 1'b1; // [R9]
                    pat = PAT_FAST;
                end
                default: pat = PAT_OFF; // [R3]
            endcase
        end else begin
            case (i_op_state)
                OP_NET_CONFIG: begin
                    cr = 1'b1; // [R11]
                    pat = PAT_FAST;
                end
                OP_LINK_DOWN: begin
                    cr = 1'b1; // [R12]
                    pat = PAT_SLOW;
                end
                OP_WAIT_CLIENT: begin
                    cg = 1'b1; // [R13]
                    pat = PAT_SLOW;
                end
                OP_IN_OPERATION: begin
                    cg = 1'b1; // [R8]
                    pat = PAT_STEADY;
                end
                OP_NO_FIRMWARE: begin
                    cr = 1'b1; // [R18]
                    cg = 1'b1;
                    pat = PAT_STEADY;
                end
                default: pat = PAT_OFF; // [R3]
            endcase
        end
    end

    // ----------------------------------------
    // led drive, fault over identify over state
    // ----------------------------------------
    always_comb begin
        case (pat)
            PAT_STEADY: begin
                red_d = cr;
                green_d = cg;
            end
            PAT_FAST: begin
                red_d = cr & fast_ph_q;
                green_d = cg & fast_ph_q;
            end
            PAT_SLOW: begin
                red_d = cr & slow_ph_q;
                green_d = cg & slow_ph_q;
            end
            default: begin
                red_d = 1'b0;
                green_d = 1'b0;
            end
        endcase

        // identify ignored while the state is OP_INACTIVE
        if (i_identify && i_op_state != OP_INACTIVE) begin
            red_d = slow_ph_q; // [R10]
            green_d = ~slow_ph_q;
        end
        if (fault_any) begin
            red_d = (fst_q == FS_ON); // [R21]
            green_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            red_q <= 1'b0;
            green_q <= 1'b0;
        end else begin
            red_q <= red_d;
            green_q <= green_d;
        end
    end

    // orange shows as both outputs lit
    assign o_led_red = red_q; // [R2]
    assign o_led_green = green_q;
endmodule

// *** dv/led_operator.sv ***
// operator model that reads red flash codes off the status led
`timescale 1ns/1ps
module led_operator #(
    parameter int unsigned FAST_HALF = 4
) (
    input wire logic i_clk,
    input wire logic i_red,
    output logic [3:0] o_burst = 4'h0,
    output logic [7:0] o_bursts = 8'h00
);
    logic prev = 1'h0;
    logic [3:0] cnt = 4'h0;
    logic [7:0] dark = 8'h00;
    // a dark gap of three slots closes a burst
    always @(posedge i_clk) begin
        prev <= i_red;
        dark <= i_red ? 8'h00 : dark + 8'h01;
        if (i_red && !prev) begin
            cnt <= cnt + 4'h1;
        end else if (dark == 3 * FAST_HALF && cnt != 4'h0) begin
            o_burst <= cnt;
            o_bursts <= o_bursts + 8'h01;
            cnt <= 4'h0;
        end
    end
endmodule

// *** dv/charger_status_led_sequencer_properties.sv ***
// checker for the charger status led sequencer
`timescale 1ns/1ps
module led_chk
    import status_led_pkg::*;
#(
    parameter int unsigned FAST_HALF = 4,
    parameter int unsigned SLOW_HALF = 20
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_managed,
    input wire status_led_pkg::op_state_t i_op_state,
    input wire logic [status_led_pkg::FAULT_W-1:0] i_fault,
    input wire logic [status_led_pkg::FAULT_W-1:0] i_fault_monitor_en,
    input wire logic i_identify,
    input wire logic o_led_red,
    input wire logic o_led_green
);
    logic flt;
    logic calm;
    logic g_q;
    logic [3:0] op_q;
    logic [7:0] run_q;
    logic [7:0] run_d;
    logic [7:0] stab_q;
    logic [7:0] stab_d;
    assign flt = !i_managed && ((i_fault & i_fault_monitor_en) != 7'h00);
    assign calm = !flt && !i_identify && !i_managed;
    // cycles since green last changed, cycles the state has been held
    always_comb begin
        run_d = (o_led_green != g_q) ? 8'h00 : run_q + 8'h01;
        stab_d = (calm && i_op_state == op_q && stab_q < 8'hF0) ? stab_q + 8'h01 : 8'h00;
        if (!i_rst_b) begin
            run_d = 8'h00;
            stab_d = 8'h00;
        end
    end
    always_ff @(posedge i_clk) begin
        run_q <= run_d;
        stab_q <= stab_d;
        g_q <= o_led_green;
        op_q <= i_op_state;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    AST_RESET_DARK: assert property ($rose(i_rst_b) |-> !o_led_red && !o_led_green)
        else $error("led lit at reset release");
    AST_INACTIVE_DARK: assert property (i_op_state == OP_INACTIVE && !flt |=> !o_led_red && !o_led_green)
        else $error("led lit while inactive");
    AST_ORANGE_BLINK: assert property (calm && i_op_state inside {OP_PREHEAT, OP_WAIT_ENABLE} |=> o_led_red == o_led_green)
        else $error("orange blink not red plus green");
    AST_FAST_HALF: assert property (o_led_green != g_q && i_op_state == OP_PREHEAT && stab_q > run_q + 8'h04
        |-> run_q == FAST_HALF - 1)
        else $error("fast blink half period wrong");
    AST_SLOW_HALF: assert property (o_led_green != g_q && i_op_state == OP_WAIT_VEHICLE && stab_q > run_q + 8'h04
        |-> run_q == SLOW_HALF - 1)
        else $error("slow blink half period wrong");
    AST_CHARGE_GREEN: assert property (calm && i_op_state == OP_CHARGING |=> o_led_green && !o_led_red)
        else $error("charging not steady green");
    AST_MANAGED_GREEN: assert property (i_managed && !i_identify && i_op_state == OP_IN_OPERATION
        |=> o_led_green && !o_led_red)
        else $error("managed operation not steady green");
    AST_NO_FIRMWARE: assert property (i_managed && !i_identify && i_op_state == OP_NO_FIRMWARE
        |=> o_led_red && o_led_green)
        else $error("no firmware not steady orange");
    AST_FAULT_RED: assert property (flt |=> !o_led_green)
        else $error("green lit during fault code");
    AST_IDENTIFY_ALT: assert property (i_identify && !flt && i_op_state != OP_INACTIVE |=> o_led_red != o_led_green)
        else $error("identify not alternating");
endmodule
bind charger_status_led_sequencer led_chk #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF)) led_chk_inst (
    .i_clk, .i_rst_b, .i_managed, .i_op_state, .i_fault, .i_fault_monitor_en, .i_identify, .o_led_red, .o_led_green);

// *** dv/tb.sv ***
// self-checking bench for the charger status led sequencer
`timescale 1ns/1ps
module tb;
    import status_led_pkg::*;
    localparam int unsigned FH = 4;
    logic i_clk = 1'h0;
    logic i_rst_b = 1'h0;
    logic i_managed = 1'h0;
    op_state_t i_op_state = OP_PREHEAT;
    logic [FAULT_W-1:0] i_fault = 7'h00;
    logic [FAULT_W-1:0] i_fault_monitor_en = 7'h7B;
    logic i_identify = 1'h0;
    logic o_led_red;
    logic o_led_green;
    logic [3:0] burst;
    logic [7:0] bursts;
    int bad_count = 0;
    int check_count = 0;
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    charger_status_led_sequencer #(.FAST_HALF(FH), .SLOW_HALF(5 * FH)) charger_status_led_sequencer_inst (
        .i_clk, .i_rst_b, .i_managed, .i_op_state, .i_fault, .i_fault_monitor_en, .i_identify, .o_led_red, .o_led_green);
    led_operator #(.FAST_HALF(FH)) led_operator_inst (.i_clk, .i_red(o_led_red), .o_burst(burst), .o_bursts(bursts));
    task automatic conclude();
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // toggles and lit cycles of red and green over 40 cycles
    task automatic watch(input logic [1:0] mi, input op_state_t s, input logic [31:0] e);
        logic pr;
        logic pg;
        logic [7:0] n [4] = '{default: 8'h00};
        @(negedge i_clk);
        {i_managed, i_identify} = mi;
        i_op_state = s;
        i_fault = mi[1] ? 7'h7F : 7'h04;
        repeat (3) @(negedge i_clk);
        {pr, pg} = {o_led_red, o_led_green};
        repeat (40) begin
            @(negedge i_clk);
            n[0] += 8'(o_led_red ^ pr);
            n[1] += 8'(o_led_green ^ pg);
            n[2] += 8'(o_led_red);
            n[3] += 8'(o_led_green);
            {pr, pg} = {o_led_red, o_led_green};
        end
        chk({n[0], n[1], n[2], n[3]}, e);
    endtask
    task automatic states();
        watch(2'h1, OP_INACTIVE, 32'h00000000);
        watch(2'h0, OP_PREHEAT, 32'h0A0A1414);
        watch(2'h0, OP_WAIT_ENABLE, 32'h02021414);
        watch(2'h0, OP_WAIT_CABLE, 32'h000A0014);
        watch(2'h0, OP_WAIT_VEHICLE, 32'h00020014);
        watch(2'h0, OP_CHARGING, 32'h00000028);
        watch(2'h0, OP_EMERG_UNLOCK, 32'h0A001400);
        watch(2'h1, OP_CHARGING, 32'h02021414);
        watch(2'h2, OP_NET_CONFIG, 32'h0A001400);
        watch(2'h2, OP_LINK_DOWN, 32'h02001400);
        watch(2'h2, OP_WAIT_CLIENT, 32'h00020014);
        watch(2'h2, OP_IN_OPERATION, 32'h00000028);
        watch(2'h2, OP_NO_FIRMWARE, 32'h00002828);
        watch(2'h3, OP_WAIT_CLIENT, 32'h02021414);
    endtask
    task automatic flash(input logic [6:0] f, input logic [3:0] n);
        logic [7:0] b0;
        @(negedge i_clk);
        {i_managed, i_identify, i_fault_monitor_en, i_fault} = {2'h0, 7'h7F, 7'h00};
        i_op_state = OP_CHARGING;
        repeat (40) @(negedge i_clk);
        i_fault = f;
        b0 = bursts;
        for (int i = 0; i < 400 && bursts - b0 < 8'h02; i++) begin
            @(negedge i_clk);
        end
        if (bursts - b0 < 8'h02) begin
            bad_count++;
            $display("BAD %0t no flash code", $time);
            conclude();
        end else begin
            chk({28'h0000000, burst}, {28'h0000000, n});
        end
    endtask
    task automatic flashes();
        for (int k = 0; k < FAULT_W; k++) begin
            flash(7'h01 << k, 4'(k + 1));
        end
        flash(7'h60, 4'h6);
    endtask
    task automatic reset_run();
        logic [7:0] lo = 8'h00;
        @(negedge i_clk);
        {i_rst_b, i_managed, i_identify, i_fault} = {3'h0, 7'h00};
        i_op_state = OP_PREHEAT;
        repeat (16) @(negedge i_clk);
        i_rst_b = 1'h1;
        repeat (FH) begin
            @(negedge i_clk);
            lo += 8'(o_led_red | o_led_green);
        end
        repeat (2) @(negedge i_clk);
        chk({16'h0000, lo, 7'h00, o_led_red}, 32'h00000001);
    endtask
    initial begin
        reset_run();
        states();
        flashes();
        reset_run();
        conclude();
    end
endmodule
